// File: hw/fbci_pkg.sv
// Constants and carrier types for the flash bus command host controller
package fbci_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int GLITCH_NS = 5;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_ACCESS_NS = 80;
  localparam int READ_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVER_NS = 50;
  localparam int RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ABORT_US = 10;
  localparam int ABORT_CYC = (ABORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ---------------------------------------------------------------
  // Unlock addresses and command codes
  // ---------------------------------------------------------------
  localparam logic [11:0] UNLK1_WORD = 12'h555;
  localparam logic [11:0] UNLK2_WORD = 12'h2aa;
  localparam logic [11:0] UNLK1_BYTE = 12'haaa;
  localparam logic [11:0] UNLK2_BYTE = 12'h555;
  localparam logic [7:0] CODE_UNLK1 = 8'haa;
  localparam logic [7:0] CODE_UNLK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_PROG = 8'ha0;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_BLOCK = 8'h30;
  localparam logic [7:0] CODE_SUSP = 8'hb0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [1:0] ID_MAKER = 2'h0;
  localparam logic [1:0] ID_PART = 2'h1;
  localparam logic [1:0] ID_PROT = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FBCI_CMD_READ = 4'h0, FBCI_CMD_RESET = 4'h1, FBCI_CMD_RESET3 = 4'h2,
    FBCI_CMD_IDENT = 4'h3, FBCI_CMD_PROG = 4'h4, FBCI_CMD_CHIP = 4'h5,
    FBCI_CMD_BLOCK = 4'h6, FBCI_CMD_SUSP = 4'h7, FBCI_CMD_RESUME = 4'h8,
    FBCI_CMD_ADDBLK = 4'h9, FBCI_CMD_IDREAD = 4'ha
  } fbci_cmd_t;

  typedef struct packed {
    fbci_cmd_t cmd;
    logic [19:0] addr;
    logic [15:0] data;
    logic slow_abort;
  } fbci_req_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } fbci_cycle_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fbci_strobe_t;

  localparam logic [2:0] SEQ_MAX = 3'h6;
endpackage

// File: hw/fbci_host.sv
// Host-side controller that issues bus cycles and command sequences to the flash
module fbci_host import fbci_pkg::*; #(
  parameter int ABORT_WAIT = ABORT_CYC
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire fbci_req_t req_in,
  input wire logic byte_mode_in,
  input wire logic [15:0] flash_dq_in,
  input wire logic ready_busy_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic device_busy_out,
  output fbci_strobe_t flash_strobe_out,
  output logic [19:0] flash_addr_out,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_byte_n_out
);
  // Refuse settings the sequencer cannot serve, at elaboration
  if (ABORT_WAIT < 1) begin : g_bad_abort
    $error("ABORT_WAIT must be at least one cycle");
  end
  if (STROBE_CYC * CLK_PERIOD_PS <= GLITCH_NS * 1000) begin : g_bad_strobe
    $error("strobe too short");
  end

  typedef enum logic [2:0] {
    FBCI_IDLE = 3'b000, FBCI_SETUP = 3'b001, FBCI_PULSE = 3'b011,
    FBCI_HOLD = 3'b010, FBCI_READ = 3'b110, FBCI_WAIT = 3'b111
  } fbci_state_t;

  fbci_state_t state;
  fbci_req_t cur;
  logic [2:0] step;
  logic [2:0] len;
  logic [31:0] cnt;
  logic rb_s1, rb_s2, rb_s3;
  logic rb_low;
  logic [11:0] u1, u2;
  fbci_cycle_t next_cycle;
  logic [31:0] next_wait;

  // ---------------------------------------------------------------
  // Ready/busy pin synchroniser, three stages
  // ---------------------------------------------------------------
  // A change counts only once stages two and three agree
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
      rb_s3 <= 1'b1;
      rb_low <= 1'b0;
    end else begin
      rb_s1 <= ready_busy_in;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (rb_s2 == rb_s3) begin
        rb_low <= ~rb_s3;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      device_busy_out <= 1'b0;
    end else begin
      device_busy_out <= rb_low;
    end
  end

  // ---------------------------------------------------------------
  // Command sequence table
  // ---------------------------------------------------------------
  // Unlock addresses follow the bus width; codes stay the same
  assign u1 = byte_mode_in ? UNLK1_BYTE : UNLK1_WORD;
  assign u2 = byte_mode_in ? UNLK2_BYTE : UNLK2_WORD;

  always_comb begin
    next_cycle = '{addr: {8'h00, u1}, data: {8'h00, CODE_UNLK1}};
    if (step == 3'h1 || step == 3'h4) begin
      next_cycle = '{addr: {8'h00, u2}, data: {8'h00, CODE_UNLK2}};
    end else if (step == 3'h3) begin
      next_cycle = '{addr: {8'h00, u1}, data: {8'h00, CODE_UNLK1}};
    end
    case (cur.cmd)
      FBCI_CMD_RESET: next_cycle = '{addr: cur.addr, data: {8'h00, CODE_RESET}};
      FBCI_CMD_SUSP: next_cycle = '{addr: cur.addr, data: {8'h00, CODE_SUSP}};
      FBCI_CMD_RESUME: next_cycle = '{addr: cur.addr, data: {8'h00, CODE_RESUME}};
      FBCI_CMD_ADDBLK: next_cycle = '{addr: cur.addr, data: {8'h00, CODE_BLOCK}};
      FBCI_CMD_RESET3: begin
        if (step == 3'h2) next_cycle = '{addr: cur.addr, data: {8'h00, CODE_RESET}};
      end
      FBCI_CMD_IDENT: begin
        if (step == 3'h2) next_cycle.data = {8'h00, CODE_IDENT};
      end
      FBCI_CMD_PROG: begin
        if (step == 3'h2) next_cycle.data = {8'h00, CODE_PROG};
        if (step == 3'h3) next_cycle = '{addr: cur.addr, data: cur.data};
      end
      FBCI_CMD_CHIP, FBCI_CMD_BLOCK: begin
        if (step == 3'h2) next_cycle.data = {8'h00, CODE_ERASE};
        if (step == 3'h5 && cur.cmd == FBCI_CMD_CHIP) next_cycle.data = {8'h00, CODE_CHIP};
        if (step == 3'h5 && cur.cmd == FBCI_CMD_BLOCK) begin
          next_cycle = '{addr: cur.addr, data: {8'h00, CODE_BLOCK}};
        end
      end
      default: next_cycle = '{addr: cur.addr, data: cur.data};
    endcase
    if (byte_mode_in) next_cycle.data[15:8] = 8'h00;
  end

  // Wait after the last write: long for aborting resets, else recovery gap
  always_comb begin
    next_wait = 32'(RECOVER_CYC);
    if (cur.slow_abort && (cur.cmd == FBCI_CMD_RESET || cur.cmd == FBCI_CMD_RESET3)) begin
      next_wait = 32'(ABORT_WAIT);
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  // Every write is OE high, address set before strobes fall, data held past rise
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= FBCI_IDLE;
      cur <= '0;
      step <= 3'h0;
      len <= 3'h0;
      cnt <= 32'h0;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 16'h0000;
      flash_strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      flash_addr_out <= 20'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_out <= 1'b0;
      flash_byte_n_out <= 1'b1;
    end else begin
      rsp_valid_out <= 1'b0;
      flash_byte_n_out <= ~byte_mode_in;
      case (state)
        FBCI_IDLE: begin
          req_ready_out <= ~rb_low;
          flash_strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          flash_dq_oe_out <= 1'b0;
          if (req_valid_in && req_ready_out) begin
            req_ready_out <= 1'b0;
            cur <= req_in;
            step <= 3'h0;
            cnt <= 32'(SETUP_CYC);
            case (req_in.cmd)
              FBCI_CMD_READ, FBCI_CMD_IDREAD: begin
                len <= 3'h0;
                flash_addr_out <= req_in.addr;
                state <= FBCI_READ;
              end
              FBCI_CMD_RESET3, FBCI_CMD_IDENT: len <= 3'h3;
              FBCI_CMD_PROG: len <= 3'h4;
              FBCI_CMD_CHIP, FBCI_CMD_BLOCK: len <= SEQ_MAX;
              default: len <= 3'h1;
            endcase
            if (req_in.cmd != FBCI_CMD_READ && req_in.cmd != FBCI_CMD_IDREAD) begin
              state <= FBCI_SETUP;
            end
          end
        end
        FBCI_SETUP: begin
          // Address and data settle with strobes high and OE held high
          flash_addr_out <= next_cycle.addr;
          flash_dq_out <= next_cycle.data;
          flash_dq_oe_out <= 1'b1;
          flash_strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          if (cnt <= 32'h1) begin
            cnt <= 32'(STROBE_CYC);
            state <= FBCI_PULSE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        FBCI_PULSE: begin
          // Pulse spans many ns so it is never mistaken for a glitch
          flash_strobe_out <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
          if (cnt <= 32'h1) begin
            cnt <= 32'(SETUP_CYC);
            state <= FBCI_HOLD;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        FBCI_HOLD: begin
          // Strobes rise while data still driven
          flash_strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          if (cnt <= 32'h1) begin
            if (step == len - 3'h1) begin
              flash_dq_oe_out <= 1'b0;
              cnt <= next_wait;
              state <= FBCI_WAIT;
            end else begin
              step <= step + 3'h1;
              cnt <= 32'(SETUP_CYC);
              state <= FBCI_SETUP;
            end
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        FBCI_READ: begin
          // Drive low only after the address stands, then sample
          flash_dq_oe_out <= 1'b0;
          flash_strobe_out <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
          // Step zero counts address setup, step one the access time
          if (cnt <= 32'h1 && !flash_strobe_out.oe_n) begin
            if (step == 3'h0) begin
              step <= 3'h1;
              cnt <= 32'(READ_CYC);
            end else begin
              rsp_data_out <= byte_mode_in ? {8'h00, flash_dq_in[7:0]} : flash_dq_in;
              rsp_valid_out <= 1'b1;
              flash_strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
              cnt <= 32'(RECOVER_CYC);
              state <= FBCI_WAIT;
            end
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        FBCI_WAIT: begin
          // Select stays high; the next read or write re-lowers it after the gap
          flash_strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          if (cnt <= 32'h1) begin
            state <= FBCI_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: state <= FBCI_IDLE;
      endcase
    end
  end
endmodule

// File: sim/fbci_host_properties.sv
// Checker of host strobe, data and handshake timing
module fbci_host_properties import fbci_pkg::*; (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic byte_mode_in,
  input wire logic ready_busy_in,
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  input wire logic device_busy_out,
  input wire fbci_strobe_t flash_strobe_out,
  input wire logic [15:0] flash_dq_out,
  input wire logic [19:0] flash_addr_out,
  input wire logic flash_dq_oe_out,
  input wire logic flash_byte_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic ce_n, oe_n, we_n;
  assign {ce_n, oe_n, we_n} = flash_strobe_out;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Strobe shape and who owns the data lines
  a_pulse_long: assert property ($fell(we_n) |-> !we_n [*8])
    else $error("Write pulse too short");
  a_addr_setup: assert property ($fell(we_n) |-> $stable(flash_addr_out) && flash_dq_oe_out)
    else $error("Address moved at write start");
  a_data_hold: assert property ($rose(we_n) |-> flash_dq_oe_out && $stable(flash_dq_out))
    else $error("Data moved at write end");
  a_write_oe_high: assert property (!we_n |-> oe_n && !ce_n)
    else $error("Output enable low in a write");
  a_read_strobes: assert property (!oe_n |-> !ce_n && we_n && !flash_dq_oe_out)
    else $error("Bad read strobes");
  // Handshake gating: busy pin, read recovery, width pin
  a_busy_gate: assert property (!ready_busy_in [*6] |-> !req_ready_out && device_busy_out)
    else $error("Ready while flash busy");
  a_read_recover: assert property ($rose(oe_n) |-> !req_ready_out [*8])
    else $error("No gap after read");
  a_width_pin: assert property (flash_byte_n_out == !$past(byte_mode_in))
    else $error("Width pin wrong");
  cover property (rsp_valid_out);
  cover property ($fell(we_n));
  cover property (device_busy_out);
endmodule
bind fbci_host fbci_host_properties fbci_host_properties_inst (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .byte_mode_in(byte_mode_in), .ready_busy_in(ready_busy_in),
  .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
  .device_busy_out(device_busy_out), .flash_strobe_out(flash_strobe_out),
  .flash_dq_out(flash_dq_out), .flash_addr_out(flash_addr_out),
  .flash_dq_oe_out(flash_dq_oe_out), .flash_byte_n_out(flash_byte_n_out));

// File: sim/fbci_flash_model.sv
// Behavioural flash device answering the host's bus cycles
module fbci_flash_model import fbci_pkg::*; #(
  parameter logic [15:0] MAKER_ID = 16'h00a5, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h00c3 // Arbitrary value
) (
  input wire logic clk_in,
  input wire fbci_strobe_t strobe_in,
  input wire logic [19:0] addr_in,
  input wire logic [15:0] host_dq_in,
  input wire logic host_oe_in,
  input wire logic byte_n_in,
  output logic [15:0] bus_dq_out,
  output logic ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  fbci_cycle_t wq[$];
  logic [19:0] lat_a;
  logic [15:0] junk = 16'h5a5a;
  logic [15:0] rdv;
  logic [7:0] cd;
  logic in_wr = 1'b0, id_mode = 1'b0, armed = 1'b0, rb_low = 1'b0;
  time t_fall = 0, busy_until = 0;
  // Address at the later fall, data at the earlier rise; short pulses dropped
  always @(strobe_in) begin
    cd = host_dq_in[7:0]; // Upper lines not decoded
    if (!strobe_in.ce_n && !strobe_in.we_n && !in_wr) begin
      in_wr = 1'b1;
      t_fall = $time;
      lat_a = addr_in;
    end else if (in_wr && (strobe_in.ce_n || strobe_in.we_n)) begin
      in_wr = 1'b0;
      if ($time - t_fall >= GLITCH_NS && !rb_low) begin
        wq.push_back('{lat_a, host_dq_in});
        if (armed) busy_until = $time + 160;
        armed = !armed && cd == CODE_PROG;
        if (cd != CODE_UNLK1 && cd != CODE_UNLK2) id_mode = cd == CODE_IDENT;
      end
    end
  end
  // Open-drain busy with pull-up; floated data shows a changing pattern
  always @(posedge clk_in) begin
    rb_low <= $time < busy_until;
    junk <= ~junk;
  end
  assign ready_busy_out = !rb_low;
  always @* begin
    rdv = {addr_in[7:0] ^ 8'h3c, addr_in[15:8]};
    if (id_mode) rdv = addr_in[1] ? {15'h0, addr_in[12]} : addr_in[0] ? PART_ID : MAKER_ID;
    if (rb_low) rdv = 16'h0080;
    if (!byte_n_in) rdv[15:8] = junk[15:8];
    if (host_oe_in) bus_dq_out = host_dq_in;
    else if (!strobe_in.ce_n && !strobe_in.oe_n) bus_dq_out = rdv;
    else bus_dq_out = junk;
  end
endmodule

// File: sim/fbci_host_tb.sv
// Self-checking bench: host controller against a flash model
module fbci_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fbci_pkg::*;
  typedef struct packed {logic [11:0] a; logic [15:0] d; logic [15:0] m; logic c;} fbci_exp_t;
  localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
  localparam logic [15:0] PART = 16'h00c3; // Arbitrary value
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, bm = 1'b0;
  fbci_req_t req = '0;
  logic rdy, rv, bsy, dqoe, byten, rb;
  logic [15:0] rd, dqo, dqi, d;
  logic [19:0] fa, a;
  fbci_strobe_t st;
  fbci_exp_t eq[$];
  int n_fail = 0, n_checks = 0, waited;
  `define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, s); end end
  always #2 clk = ~clk;
  fbci_host #(.ABORT_WAIT(20)) fbci_host_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .req_valid_in(vld), .req_in(req), .byte_mode_in(bm), .flash_dq_in(dqi),
    .ready_busy_in(rb), .req_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rd),
    .device_busy_out(bsy), .flash_strobe_out(st), .flash_addr_out(fa),
    .flash_dq_out(dqo), .flash_dq_oe_out(dqoe), .flash_byte_n_out(byten));
  fbci_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) fbci_flash_model_inst (.clk_in(clk),
    .strobe_in(st), .addr_in(fa), .host_dq_in(dqo), .host_oe_in(dqoe), .byte_n_in(byten),
    .bus_dq_out(dqi), .ready_busy_out(rb));
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded waits; a limit that runs out ends the run as a mismatch
  task automatic wait_ready();
    for (waited = 0; rdy !== 1'b1; waited++) begin
      if (waited == 3000) begin n_fail++; give_verdict(); end
      @(posedge clk);
    end
  endtask
  // Request stands until an edge at which ready was seen high
  task automatic send(fbci_cmd_t c, logic sa);
    int n;
    req <= '{c, a, d, sa};
    vld <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 3000) begin n_fail++; give_verdict(); end
    end while (rdy !== 1'b1);
    vld <= 1'b0;
    @(posedge clk); // Let the ready drop land before polling again
  endtask
  function automatic void pc(logic ck, logic [11:0] ad, logic [7:0] cd);
    eq.push_back('{ad, {8'h00, cd}, 16'h00ff, ck});
  endfunction
  // Expected write train built from the command tables
  task automatic run_cmd(fbci_cmd_t c, logic sa);
    logic [11:0] u1, u2;
    fbci_cycle_t wq[$];
    u1 = bm ? UNLK1_BYTE : UNLK1_WORD;
    u2 = bm ? UNLK2_BYTE : UNLK2_WORD;
    if (c inside {FBCI_CMD_RESET3, FBCI_CMD_IDENT, FBCI_CMD_PROG, FBCI_CMD_CHIP, FBCI_CMD_BLOCK}) begin
      pc(1'b1, u1, CODE_UNLK1);
      pc(1'b1, u2, CODE_UNLK2);
    end
    if (c inside {FBCI_CMD_CHIP, FBCI_CMD_BLOCK}) begin
      pc(1'b1, u1, CODE_ERASE);
      pc(1'b1, u1, CODE_UNLK1);
      pc(1'b1, u2, CODE_UNLK2);
    end
    case (c)
      FBCI_CMD_RESET, FBCI_CMD_RESET3: pc(1'b0, 12'h0, CODE_RESET);
      FBCI_CMD_IDENT: pc(1'b1, u1, CODE_IDENT);
      FBCI_CMD_PROG: begin
        pc(1'b1, u1, CODE_PROG);
        eq.push_back('{a[11:0], bm ? {8'h00, d[7:0]} : d, bm ? 16'h00ff : 16'hffff, 1'b1});
      end
      FBCI_CMD_CHIP: pc(1'b1, u1, CODE_CHIP);
      FBCI_CMD_SUSP: pc(1'b0, 12'h0, CODE_SUSP);
      FBCI_CMD_RESUME: pc(1'b0, 12'h0, CODE_RESUME);
      default: pc(1'b1, a[11:0], CODE_BLOCK);
    endcase
    send(c, sa);
    wait_ready();
    if (sa) `CHK("abort wait", 1'b1, waited > 36)
    wq = fbci_flash_model_inst.wq;
    `CHK("write count", eq.size(), wq.size())
    foreach (eq[i]) if (i < wq.size()) begin
      if (eq[i].c) `CHK("write addr", eq[i].a, wq[i].addr[11:0])
      `CHK("write data", eq[i].d, wq[i].data & eq[i].m)
    end
    eq.delete();
    fbci_flash_model_inst.wq.delete();
  endtask
  task automatic do_read(fbci_cmd_t c, logic [15:0] e);
    int i;
    send(c, 1'b0);
    for (i = 0; rv !== 1'b1; i++) begin
      if (i == 200) begin n_fail++; give_verdict(); end
      @(posedge clk);
    end
    `CHK("read data", bm ? {8'h00, e[7:0]} : e, rd)
  endtask
  initial begin
    void'($urandom(32'h15f9));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      bm <= b[0];
      a = $urandom;
      d = $urandom;
      @(posedge clk);
      do_read(FBCI_CMD_READ, {a[7:0] ^ 8'h3c, a[15:8]});
      for (int k = 1; k < 10; k++) begin
        a = $urandom;
        d = $urandom;
        run_cmd(fbci_cmd_t'(k), k == 1);
        $display("Command %0d width %0d done", k, b);
      end
      run_cmd(FBCI_CMD_IDENT, 1'b0);
      a[1:0] = ID_MAKER;
      do_read(FBCI_CMD_IDREAD, MAKER);
      a[1:0] = ID_PART;
      do_read(FBCI_CMD_IDREAD, PART);
      a[1:0] = ID_PROT;
      do_read(FBCI_CMD_IDREAD, {15'h0, a[12]});
      run_cmd(FBCI_CMD_RESET3, 1'b0);
      do_read(FBCI_CMD_READ, {a[7:0] ^ 8'h3c, a[15:8]});
      $display("Identification width %0d done", b);
    end
    give_verdict();
  end
endmodule
